// ==== verilog/dacio_top.v ====
// Bus interface logic of the analog output master module
`include "dacio_defs.vh"

// Function
// [RULE1] Respond only to device addresses 50-57 octal
// [RULE2] Unaddressed module takes no action
// [RULE3] Master decodes address for three expansion boards
// [RULE4] Eight select lines, one per converter number
// [RULE5] Master holds select state for expansions
// [RULE6] Selection holds until reselect, clear, power
// [RULE7] Handshake with processor or block controller
// [RULE8] Latch word into selected buffer, convert
// [RULE9] External control drives one of eight lines
// [RULE10] Sense code picks one of eight inputs
// [RULE11] External control only in the master
// [RULE12] Two channels per board, one-channel variants
// [RULE13] Resolution 10, 12 or 14 bits; the code is fixed at 12 bits
// [RULE14] Right-aligned two's complement, upper bits ignored
// [RULE15] Select command carries converter number 0-7
// [RULE16] Accept output from A, B or memory
// [RULE17] Buffer holds last value until rewrite
module dacio_top #(
    parameter [5:0] DEV_ADDR  = `DACIO_DEV_ADDR_LO,
    parameter       ONE_CHAN  = 0
) (
    input  wire                            CORE_CLK,
    input  wire                            RST,
    input  wire [`DACIO_DEV_ADDR_W-1:0]    BUS_DEV_ADDR,
    input  wire [`DACIO_FUNC_W-1:0]        BUS_FUNC,
    input  wire [`DACIO_WORD_W-1:0]        BUS_DATA,
    input  wire                            EXC_STROBE,
    input  wire                            SEL_STROBE,
    input  wire                            SENSE_STROBE,
    input  wire                            OUT_A_STROBE,
    input  wire                            OUT_B_STROBE,
    input  wire                            OUT_MEM_STROBE,
    input  wire                            BTC_REQ,
    input  wire [`DACIO_NUM_CONV-1:0]      SENSE_INPUTS,
    output reg  [`DACIO_NUM_CONV-1:0]      CONV_SELECT,
    output reg  [`DACIO_NUM_CONV-1:0]      EXTERNAL_CONTROL_LINES,
    output reg                             SENSE_RESPONSE,
    output reg                             PROC_ACK,
    output reg                             BTC_ACK,
    output reg                             LOAD_STROBE,
    output reg  [`DACIO_CONV_IDX_W-1:0]    LOAD_IDX,
    output reg  [`DACIO_RES_BITS-1:0]      LOAD_DATA,
    output reg  [`DACIO_RES_BITS-1:0]      MON_DATA
);

    // ****************************************
    // Local states of the load handshake
    // ****************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LOAD = 3'b010;
    localparam [2:0] ST_ACK  = 3'b100;

    // Converter number that a single-channel master lacks
    localparam [2:0] MISSING_CONV = 3'h1;

    reg [2:0]                       state;
    reg [2:0]                       next_state;
    reg                             from_btc;
    reg [`DACIO_CONV_IDX_W-1:0]     cur_idx;
    reg [`DACIO_RES_BITS-1:0]       hold_word;
    wire                            addressed;
    wire                            out_req;
    wire                            chan_ok;
    wire [`DACIO_RES_BITS-1:0]      mem_rd;
    // Decoded lines and request qualifiers
    wire [`DACIO_NUM_CONV-1:0]      func_hot;
    wire [`DACIO_NUM_CONV-1:0]      sel_hit;
    wire [`DACIO_NUM_CONV-1:0]      exc_hit;
    wire [`DACIO_NUM_CONV-1:0]      sense_bit;
    wire [`DACIO_NUM_BOARDS-1:0]    board_sel;
    wire                            any_sel;
    wire                            btc_ok;
    wire                            take_req;

    // One-hot decode, used for select and control lines
    function [`DACIO_NUM_CONV-1:0] onehot8;
        input [`DACIO_CONV_IDX_W-1:0] code;
        begin
            onehot8 = 8'h01 << code;
        end
    endfunction

    // ****************************************
    // Per-line and per-board decode
    // ****************************************
    // Code turned into eight lines once, shared below
    assign func_hot = onehot8(BUS_FUNC);

    genvar g;
    generate
        // One AND per line on the shared decode keeps each output one gate deep
        for (g = 0; g < `DACIO_NUM_CONV; g = g + 1) begin : g_line
            // [RULE4] [RULE15] select line for converter number g
            assign sel_hit[g]   = addressed & SEL_STROBE & func_hot[g];
            // [RULE9] control line g pulses on its own code
            assign exc_hit[g]   = addressed & EXC_STROBE & func_hot[g];
            // [RULE10] only the addressed sense input passes
            assign sense_bit[g] = SENSE_INPUTS[g] & func_hot[g];
        end
        // [RULE3] [RULE5] two converters per board, four boards
        for (g = 0; g < `DACIO_NUM_BOARDS; g = g + 1) begin : g_board
            // Board g holds converters 2g and 2g+1
            assign board_sel[g] = CONV_SELECT[2*g] | CONV_SELECT[2*g+1];
        end
    endgenerate

    // A load needs some board here to hold a selection
    assign any_sel = |board_sel;

    // ****************************************
    // Address decode
    // ****************************************
    // [RULE1] range and own-address match
    // [RULE2] nothing happens unless addressed
    assign addressed = (BUS_DEV_ADDR == DEV_ADDR) &&
                       (DEV_ADDR >= `DACIO_DEV_ADDR_LO) &&
                       (DEV_ADDR <= `DACIO_DEV_ADDR_HI);
    // [RULE16] any of three output instructions
    assign out_req = addressed & (OUT_A_STROBE | OUT_B_STROBE | OUT_MEM_STROBE);

    // [RULE12] single-channel master lacks converter 1
    assign chan_ok = !(ONE_CHAN != 0 && cur_idx == MISSING_CONV);

    // ****************************************
    // Converter selection
    // ****************************************
    // [RULE3] [RULE5] master holds selects for all boards
    // [RULE6] held until reselect or system clear
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            CONV_SELECT <= `DACIO_SEL_RESET;
        end else if (|sel_hit) begin
            // [RULE4] [RULE15] number in function field
            CONV_SELECT <= sel_hit;
        end
    end

    // ****************************************
    // Selected converter number
    // ****************************************
    // Kept beside the lines so the write path needs no encoder
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cur_idx <= {`DACIO_CONV_IDX_W{1'b0}};
        end else if (|sel_hit) begin
            cur_idx <= BUS_FUNC;
        end
    end

    // ****************************************
    // External control and sense
    // ****************************************
    // [RULE9] [RULE11] one line pulsed, master only
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            EXTERNAL_CONTROL_LINES <= `DACIO_EXC_RESET;
        end else begin
            // Pulsed, not held: lines fall back the cycle after
            EXTERNAL_CONTROL_LINES <= exc_hit;
        end
    end

    // ****************************************
    // Sense return
    // ****************************************
    // [RULE10] selected input level returned for one cycle
    // Level is sampled on the strobe edge only
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SENSE_RESPONSE <= 1'b0;
        end else begin
            SENSE_RESPONSE <= addressed & SENSE_STROBE & (|sense_bit);
        end
    end

    // ****************************************
    // Buffer load handshake
    // ****************************************
    // ****************************************
    // Request acceptance
    // ****************************************
    // [RULE7] a controller offer still held during its ack is not taken again
    // Offers that arrive while busy are simply not taken
    assign btc_ok   = BTC_REQ & addressed & ~BTC_ACK;
    assign take_req = (state == ST_IDLE) && (out_req || btc_ok) && any_sel;

    // Next state; a request waits in idle only
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_req) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_ACK;
            end
            ST_ACK: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Handshake state register; outputs get their own processes
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Word capture
    // ****************************************
    // [RULE7] capture side and word on the take edge
    // [RULE14] low bits kept, sign at top implemented bit
    // Word is held here so the bus may move on after the take edge
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            from_btc  <= 1'b0;
            hold_word <= {`DACIO_RES_BITS{1'b0}};
        end else if (take_req) begin
            // Processor wins when both offer a word
            from_btc  <= ~out_req;
            hold_word <= BUS_DATA[`DACIO_RES_BITS-1:0];
        end
    end

    // ****************************************
    // Converter write strobe
    // ****************************************
    // [RULE8] one write per accepted word except to the missing channel, converted at once
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            LOAD_STROBE <= 1'b0;
            LOAD_IDX    <= {`DACIO_CONV_IDX_W{1'b0}};
            LOAD_DATA   <= {`DACIO_RES_BITS{1'b0}};
        end else if (state == ST_LOAD) begin
            // [RULE12] missing channel is never written
            LOAD_STROBE <= chan_ok;
            LOAD_IDX    <= cur_idx;
            LOAD_DATA   <= hold_word;
        end else begin
            LOAD_STROBE <= 1'b0;
        end
    end

    // ****************************************
    // Transfer acknowledge
    // ****************************************
    // [RULE7] acknowledge to whichever party supplied data
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PROC_ACK <= 1'b0;
            BTC_ACK  <= 1'b0;
        end else if (state == ST_ACK) begin
            PROC_ACK <= ~from_btc;
            BTC_ACK  <= from_btc;
        end else begin
            PROC_ACK <= 1'b0;
            BTC_ACK  <= 1'b0;
        end
    end

    // ****************************************
    // Buffer store
    // ****************************************
    // [RULE13] [RULE17] fixed-width words held until rewrite
    dacio_buf_mem dacio_buf_mem_inst (
        .clk     (CORE_CLK),
        .rst     (RST),
        .wr_en   (LOAD_STROBE),
        .wr_idx  (LOAD_IDX),
        .wr_data (LOAD_DATA),
        .rd_idx  (cur_idx),
        .rd_data (mem_rd)
    );

    // ****************************************
    // Readback
    // ****************************************
    // Readback of selected buffer, one extra stage
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            MON_DATA <= {`DACIO_RES_BITS{1'b0}};
        end else begin
            MON_DATA <= mem_rd;
        end
    end

endmodule // dacio_top

// ==== verilog/dacio_defs.vh ====
// Constants for the analog output module bus interface
`ifndef DACIO_DEFS_VH
`define DACIO_DEFS_VH

// ****************************************
// Device address range and bus fields
// ****************************************
`define DACIO_DEV_ADDR_LO    6'o50
`define DACIO_DEV_ADDR_HI    6'o57
`define DACIO_DEV_ADDR_W     6
`define DACIO_FUNC_W         3
`define DACIO_WORD_W         16

// ****************************************
// Converter organisation
// ****************************************
`define DACIO_NUM_CONV       8
`define DACIO_CONV_IDX_W     3
`define DACIO_NUM_BOARDS     4
`define DACIO_RES_BITS       12
`define DACIO_MASTER_CONVS   2

// ****************************************
// Reset values
// ****************************************
`define DACIO_SEL_RESET      8'h00
`define DACIO_EXC_RESET      8'h00

`endif

// ==== verilog/dacio_buf_mem.v ====
// Eight-word converter buffer store with registered read data
`include "dacio_defs.vh"

module dacio_buf_mem (
    input  wire                            clk,
    input  wire                            rst,
    input  wire                            wr_en,
    input  wire [`DACIO_CONV_IDX_W-1:0]    wr_idx,
    input  wire [`DACIO_RES_BITS-1:0]      wr_data,
    input  wire [`DACIO_CONV_IDX_W-1:0]    rd_idx,
    output reg  [`DACIO_RES_BITS-1:0]      rd_data
);

    reg [`DACIO_RES_BITS-1:0] mem [0:`DACIO_NUM_CONV-1];
    integer i;

    // Words hold until rewritten or cleared
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `DACIO_NUM_CONV; i = i + 1) begin
                mem[i] <= {`DACIO_RES_BITS{1'b0}};
            end
            rd_data <= {`DACIO_RES_BITS{1'b0}};
        end else begin
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= mem[rd_idx];
        end
    end

endmodule // dacio_buf_mem

// ==== bench/dacio_props.sv ====
// Checker for the converter module bus interface
`include "dacio_defs.vh"
module dacio_props #(parameter [5:0] DEV_ADDR = `DACIO_DEV_ADDR_LO) (
    input wire        CORE_CLK,
    input wire        RST,
    input wire [5:0]  BUS_DEV_ADDR,
    input wire [2:0]  BUS_FUNC,
    input wire [15:0] BUS_DATA,
    input wire        EXC_STROBE,
    input wire        SEL_STROBE,
    input wire        SENSE_STROBE,
    input wire        OUT_A_STROBE,
    input wire        OUT_B_STROBE,
    input wire        OUT_MEM_STROBE,
    input wire [7:0]  SENSE_INPUTS,
    input wire [7:0]  CONV_SELECT,
    input wire [7:0]  EXTERNAL_CONTROL_LINES,
    input wire        SENSE_RESPONSE,
    input wire        PROC_ACK,
    input wire        BTC_ACK,
    input wire        LOAD_STROBE,
    input wire [2:0]  LOAD_IDX,
    input wire [11:0] LOAD_DATA
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Address match and request helpers
    wire        hit     = BUS_DEV_ADDR == DEV_ADDR;
    wire [11:0] word_lo = BUS_DATA[11:0];
    wire        out_req = hit && (OUT_A_STROBE || OUT_B_STROBE || OUT_MEM_STROBE);
    property p_sel; hit && SEL_STROBE |=> CONV_SELECT == (8'h01 << $past(BUS_FUNC)); endproperty
    a_sel: assert property (p_sel) else $error("select line wrong");
    property p_hold; !(hit && SEL_STROBE) |=> $stable(CONV_SELECT); endproperty
    a_hold: assert property (p_hold) else $error("select changed");
    property p_exc; hit && EXC_STROBE |=> EXTERNAL_CONTROL_LINES == (8'h01 << $past(BUS_FUNC)); endproperty
    a_exc: assert property (p_exc) else $error("control line wrong");
    property p_quiet; !(hit && EXC_STROBE) |=> EXTERNAL_CONTROL_LINES == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("stray control line");
    property p_sense; hit && SENSE_STROBE |=> SENSE_RESPONSE == $past(SENSE_INPUTS[BUS_FUNC]); endproperty
    a_sense: assert property (p_sense) else $error("sense level wrong");
    property p_data; LOAD_STROBE |-> LOAD_DATA == $past(word_lo, 2); endproperty
    a_data: assert property (p_data) else $error("load word wrong");
    property p_idx; LOAD_STROBE |-> $past(CONV_SELECT, 2) == (8'h01 << LOAD_IDX); endproperty
    a_idx: assert property (p_idx) else $error("load target wrong");
    property p_ack; PROC_ACK || BTC_ACK |-> $past(LOAD_STROBE); endproperty
    a_ack: assert property (p_ack) else $error("ack without load");
    property p_cause; PROC_ACK |-> $past(out_req, 3); endproperty
    a_cause: assert property (p_cause) else $error("ack without request");
    property p_once; BTC_ACK && !out_req |-> ##2 !LOAD_STROBE; endproperty
    a_once: assert property (p_once) else $error("held offer taken twice");
endmodule // dacio_props

// ==== bench/dacio_btc_model.sv ====
// Block-transfer controller model offering one word per go pulse
module dacio_btc_model (
    input  wire         clk,
    input  wire         go,
    input  wire  [3:0]  gap,
    input  wire  [15:0] word,
    input  wire         ack,
    output logic        req,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    // offer held until ack is sampled, then released
    always begin
        @(posedge go);
        repeat (gap) @(negedge clk);
        data = word;
        req = 1'b1;
        @(posedge clk iff ack);
        @(negedge clk);
        req = 1'b0;
        // Turned over so a late read of stale data shows
        data = ~word;
    end
    initial req = 1'b0;
endmodule // dacio_btc_model

// ==== bench/dacio_top_bench.sv ====
// Self-checking bench for the converter module bus interface
`include "dacio_defs.vh"
module dacio_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CORE_CLK = 0, RST = 1, go = 0;
    logic [5:0] BUS_DEV_ADDR = 6'o50, stb = 6'h00;
    logic [2:0] BUS_FUNC = 3'h0;
    logic [3:0] gap = 4'h0;
    logic [7:0] SENSE_INPUTS = 8'h00;
    logic [15:0] cpu_data = 16'h0000, btc_word = 16'h0000;
    wire [15:0] btc_data;
    wire BTC_REQ, SENSE_RESPONSE, PROC_ACK, BTC_ACK, LOAD_STROBE;
    wire [15:0] BUS_DATA = BTC_REQ ? btc_data : cpu_data;
    // Strobe order: exc, sel, sense, out a, out b, out mem
    wire EXC_STROBE = stb[0], SEL_STROBE = stb[1], SENSE_STROBE = stb[2];
    wire OUT_A_STROBE = stb[3], OUT_B_STROBE = stb[4], OUT_MEM_STROBE = stb[5];
    wire [7:0] CONV_SELECT, EXTERNAL_CONTROL_LINES;
    wire [2:0] LOAD_IDX;
    wire [11:0] LOAD_DATA, MON_DATA;
    int n_errors = 0, checks = 0, n;
    // Function code beside a sense pattern whose addressed bit alternates
    logic [10:0] rows [0:7] = '{{3'h0, 8'h01}, {3'h1, 8'hFD}, {3'h2, 8'h04}, {3'h3, 8'hF7},
                                {3'h4, 8'h10}, {3'h5, 8'hDF}, {3'h6, 8'h40}, {3'h7, 8'h7F}};
    dacio_top #(.DEV_ADDR(6'o50)) dacio_top_inst (.*);
    dacio_btc_model dacio_btc_model_inst (.clk(CORE_CLK), .go(go), .gap(gap), .word(btc_word),
                                          .ack(BTC_ACK), .req(BTC_REQ), .data(btc_data));
    always #50 CORE_CLK = ~CORE_CLK;
    // ****************
    // Bus tasks
    // ****************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobe; returns while the one-cycle answer stands
    task op(input int k, input logic [5:0] a, input logic [2:0] f, input logic [15:0] d);
        @(negedge CORE_CLK);
        stb = 6'h01 << k;
        BUS_DEV_ADDR = a;
        BUS_FUNC = f;
        cpu_data = d;
        @(negedge CORE_CLK);
        stb = 6'h00;
    endtask
    task acks;
        n = 0;
        repeat (6) begin
            @(negedge CORE_CLK);
            n += (PROC_ACK === 1'b1) + (BTC_ACK === 1'b1);
        end
    endtask
    task end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the under two hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge CORE_CLK);
        n_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge CORE_CLK);
        RST = 0;
        op(3, 6'o50, 3'h0, 16'h0123);
        acks();
        chk(16'(n), 16'h0000);
        foreach (rows[i]) begin
            SENSE_INPUTS = rows[i][7:0];
            op(1, 6'o50, 3'(i), 16'h0000);
            chk(CONV_SELECT, 16'h0001 << i);
            op(0, 6'o50, 3'(i), 16'h0000);
            chk(EXTERNAL_CONTROL_LINES, 16'h0001 << i);
            chk(CONV_SELECT, 16'h0001 << i);
            op(2, 6'o50, 3'(i), 16'h0000);
            chk(SENSE_RESPONSE, 16'(rows[i][i]));
            op(3 + i % 3, 6'o50, 3'h0, {5'h1F, rows[i]});
            acks();
            chk(16'(n), 16'h0001);
            chk(MON_DATA, {5'h00, rows[i]} | 16'h0800);
        end
        // Another address must leave selection and buffers alone
        op(1, 6'o51, 3'h2, 16'h0000);
        chk(CONV_SELECT, 16'h0080);
        op(4, 6'o51, 3'h0, 16'h0AAA);
        acks();
        chk(16'(n), 16'h0000);
        op(1, 6'o50, 3'h0, 16'h0000);
        repeat (2) @(negedge CORE_CLK);
        chk(MON_DATA, {5'h00, rows[0]} | 16'h0800);
        // Block controller, prompt then slow; one ack per offer
        for (int g = 0; g < 6; g += 5) begin
            gap = 4'(g);
            btc_word = 16'hE5A0 + 16'(g);
            go = 1;
            n = 0;
            repeat (14) begin
                @(negedge CORE_CLK);
                go = 0;
                n += (BTC_ACK === 1'b1) + (PROC_ACK === 1'b1);
            end
            chk(16'(n), 16'h0001);
            chk(MON_DATA, 16'h05A0 + 16'(g));
        end
        RST = 1;
        @(negedge CORE_CLK);
        RST = 0;
        chk(CONV_SELECT, 16'h0000);
        end_of_test();
    end
endmodule // dacio_top_bench
bind dacio_top dacio_props #(.DEV_ADDR(DEV_ADDR)) dacio_props_inst (.*);
